// *** pkg/fsr_pkg.sv ***
// Constants for the flash settings readback block
package fsr_pkg;
  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_CHIP  = 8'h04;
  localparam logic [7:0] A_VID   = 8'h08;
  localparam logic [7:0] A_PID   = 8'h0c;
  localparam logic [7:0] A_PWR   = 8'h10;
  localparam logic [7:0] A_GP    = 8'h14;
  localparam logic [7:0] A_DIV   = 8'h18;
  localparam logic [7:0] A_STS   = 8'h1c;
  localparam logic [7:0] A_CLR   = 8'h20;
  localparam logic [7:0] A_EN    = 8'h24;
  localparam logic [7:0] A_IDX   = 8'h28;
  localparam logic [7:0] A_DATA  = 8'h2c;
  localparam logic [7:0] A_STATE = 8'h30;
  // ****************************************
  // Response layout
  // ****************************************
  localparam logic [7:0] CMD_READ = 8'hb0;
  localparam logic [7:0] RC_OK    = 8'h00;
  localparam logic [7:0] LEN_CHIP = 8'h0e;
  localparam logic [7:0] LEN_GP   = 8'h08;
  localparam logic [5:0] IX_CMD    = 6'h00;
  localparam logic [5:0] IX_RC     = 6'h01;
  localparam logic [5:0] IX_LEN    = 6'h02;
  localparam logic [5:0] IX_PIN0   = 6'h04;
  localparam logic [5:0] IX_PIN1   = 6'h05;
  localparam logic [5:0] IX_PIN2   = 6'h06;
  localparam logic [5:0] IX_CHIP7  = 6'h07;
  localparam logic [5:0] IX_VID_LO = 6'h08;
  localparam logic [5:0] IX_VID_HI = 6'h09;
  localparam logic [5:0] IX_PID_LO = 6'h0a;
  localparam logic [5:0] IX_PID_HI = 6'h0b;
  localparam logic [5:0] IX_PWR    = 6'h0c;
  localparam logic [5:0] IX_MA     = 6'h0d;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int B_NEG      = 6;
  localparam int B_POS      = 5;
  localparam int B_ADC_HI   = 4;
  localparam int B_ADC_LO   = 3;
  localparam int B_DAC      = 2;
  localparam int B_VAL      = 4;
  localparam int B_DIR      = 3;
  localparam int CTRL_START = 0;
  localparam int CTRL_SUB   = 1;
  localparam int ST_DONE    = 0;
  localparam int ST_INT     = 1;
  // ****************************************
  // Pin function codes
  // ****************************************
  localparam logic [2:0] F_GPIO  = 3'h0;
  localparam logic [2:0] F0_SUSP = 3'h1;
  localparam logic [2:0] F0_URX  = 3'h2;
  localparam logic [2:0] F1_CLK  = 3'h1;
  localparam logic [2:0] F1_ADC  = 3'h2;
  localparam logic [2:0] F1_UTX  = 3'h3;
  localparam logic [2:0] F1_INT  = 3'h4;
  localparam logic [2:0] F2_CFG  = 3'h1;
  localparam logic [2:0] F2_ADC  = 3'h2;
  localparam logic [2:0] F2_DAC  = 3'h3;
  // ****************************************
  // Reset values
  // ****************************************
  // Identifier reset values are arbitrary
  localparam logic [15:0] R_VID  = 16'h1234;
  localparam logic [15:0] R_PID  = 16'h5678;
  localparam logic [7:0]  R_CHIP = 8'h00;
  localparam logic [7:0]  R_PWR  = 8'h80;
  localparam logic [7:0]  R_MA   = 8'h32;
  localparam logic [7:0]  R_GP   = 8'h08;
  localparam logic [4:0]  R_DIV  = 5'h00;
endpackage : fsr_pkg

// *** pkg/fsr_edge_if.sv ***
// Interface between the top and the interrupt edge detector
`timescale 1ns/1ps
`default_nettype none
interface fsr_edge_if;
  logic level;
  logic neg_en;
  logic pos_en;
  logic evt;
  modport det (input level, input neg_en, input pos_en, output evt);
  modport ctl (output level, output neg_en, output pos_en, input evt);
endinterface : fsr_edge_if
`default_nettype wire

// *** hw/fsr_edge_det.sv ***
// Interrupt input edge detector
`timescale 1ns/1ps
`default_nettype none
module fsr_edge_det (
  input  wire logic ref_clk,
  input  wire logic rstn,
  fsr_edge_if.det   e
);
  typedef struct packed {
    logic prev;
    logic evt;
  } fsr_edge_state_t;

  fsr_edge_state_t q_ff;
  fsr_edge_state_t nxt_q;

  always_comb begin
    nxt_q      = q_ff;
    nxt_q.prev = e.level;
    nxt_q.evt  = (e.neg_en && q_ff.prev && !e.level) ||
                 (e.pos_en && !q_ff.prev && e.level);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign e.evt = q_ff.evt;

  // ****************************************
  // Checks
  // ****************************************
  chk_neg_edge: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    ($fell(e.level) && e.neg_en) |=> e.evt)
    else $error("falling edge not flagged");
  chk_pos_edge: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    ($rose(e.level) && e.pos_en) |=> e.evt)
    else $error("rising edge not flagged");
endmodule : fsr_edge_det
`default_nettype wire

// *** hw/fsr_top.sv ***
// Settings readback block with Avalon-MM registers and pin control
//
// The implementer's own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module fsr_top (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  input  wire logic [2:0]  gp_in,
  output logic      [2:0]  gp_out,
  output logic      [2:0]  gp_oe,
  input  wire logic        suspend_indicator,
  input  wire logic        usb_configured_indicator,
  input  wire logic        uart_rx_activity_indicator,
  input  wire logic        uart_tx_activity_indicator,
  output logic             analog_input_1_sel,
  output logic             analog_input_2_sel,
  output logic             analog_output_1_en,
  output logic      [1:0]  adc_vref_code,
  output logic             adc_vref_on,
  output logic             dac_ref_supply,
  output logic      [15:0] usb_vid,
  output logic      [15:0] usb_pid,
  output logic      [7:0]  usb_power_attr,
  output logic      [8:0]  usb_current_ma
);
  typedef struct packed {
    logic        wt;
    logic [31:0] rdata;
    logic        sub;
    logic [5:0]  idx;
    logic [7:0]  chip;
    logic [15:0] vid;
    logic [15:0] pid;
    logic [7:0]  pwr;
    logic [7:0]  ma;
    logic [7:0]  pin0;
    logic [7:0]  pin1;
    logic [7:0]  pin2;
    logic [4:0]  div;
    logic [4:0]  cnt;
    logic        clk;
    logic [1:0]  sts;
    logic [1:0]  en;
    logic        irq;
    logic [2:0]  out;
    logic [2:0]  oe;
    logic        ana1;
    logic        ana2;
    logic        dac;
    logic [1:0]  vref;
    logic        vref_on;
    logic        dac_sup;
    logic [8:0]  ma_o;
  } fsr_top_state_t;

  localparam fsr_top_state_t ST_RST = '{
    wt: 1'b1, chip: fsr_pkg::R_CHIP, vid: fsr_pkg::R_VID,
    pid: fsr_pkg::R_PID, pwr: fsr_pkg::R_PWR, ma: fsr_pkg::R_MA,
    pin0: fsr_pkg::R_GP, pin1: fsr_pkg::R_GP, pin2: fsr_pkg::R_GP,
    div: fsr_pkg::R_DIV, default: '0};

  fsr_top_state_t q_ff;
  fsr_top_state_t nxt_q;
  fsr_edge_if     eif ();

  logic [7:0]  rb;
  logic [31:0] rd;
  logic [31:0] wm;
  logic [1:0]  clr;
  logic [1:0]  set;

  function automatic logic [31:0] fsr_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction : fsr_merge

  // ****************************************
  // Interrupt edge detector
  // ****************************************
  assign eif.level  = gp_in[1];
  assign eif.neg_en = q_ff.chip[fsr_pkg::B_NEG] &&
                      q_ff.pin1[2:0] == fsr_pkg::F1_INT;
  assign eif.pos_en = q_ff.chip[fsr_pkg::B_POS] &&
                      q_ff.pin1[2:0] == fsr_pkg::F1_INT;

  fsr_edge_det u_edge (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .e       (eif.det)
  );

  // ****************************************
  // Response byte
  // ****************************************
  always_comb begin
    rb = 8'h00;
    case (q_ff.idx)
      fsr_pkg::IX_CMD:    rb = fsr_pkg::CMD_READ;
      fsr_pkg::IX_RC:     rb = fsr_pkg::RC_OK;
      fsr_pkg::IX_LEN:    rb = q_ff.sub ? fsr_pkg::LEN_GP
                                        : fsr_pkg::LEN_CHIP;
      fsr_pkg::IX_PIN0:   rb = q_ff.sub ? q_ff.pin0 : 8'h00;
      fsr_pkg::IX_PIN1:   rb = q_ff.sub ? q_ff.pin1 : 8'h00;
      fsr_pkg::IX_PIN2:   rb = q_ff.sub ? q_ff.pin2 : 8'h00;
      fsr_pkg::IX_CHIP7:  rb = q_ff.sub ? 8'h00 : q_ff.chip;
      fsr_pkg::IX_VID_LO: rb = q_ff.sub ? 8'h00 : q_ff.vid[7:0];
      fsr_pkg::IX_VID_HI: rb = q_ff.sub ? 8'h00 : q_ff.vid[15:8];
      fsr_pkg::IX_PID_LO: rb = q_ff.sub ? 8'h00 : q_ff.pid[7:0];
      fsr_pkg::IX_PID_HI: rb = q_ff.sub ? 8'h00 : q_ff.pid[15:8];
      fsr_pkg::IX_PWR:    rb = q_ff.sub ? 8'h00 : q_ff.pwr;
      fsr_pkg::IX_MA:     rb = q_ff.sub ? 8'h00 : q_ff.ma;
      default:            rb = 8'h00;
    endcase
  end

  // ****************************************
  // Register read mux
  // ****************************************
  always_comb begin
    rd = 32'h0000_0000;
    case (avs_address)
      fsr_pkg::A_CTRL:  rd = {30'h0, q_ff.sub, 1'b0};
      fsr_pkg::A_CHIP:  rd = {24'h0, q_ff.chip};
      fsr_pkg::A_VID:   rd = {16'h0, q_ff.vid};
      fsr_pkg::A_PID:   rd = {16'h0, q_ff.pid};
      fsr_pkg::A_PWR:   rd = {16'h0, q_ff.ma, q_ff.pwr};
      fsr_pkg::A_GP:    rd = {8'h0, q_ff.pin2, q_ff.pin1, q_ff.pin0};
      fsr_pkg::A_DIV:   rd = {27'h0, q_ff.div};
      fsr_pkg::A_STS:   rd = {30'h0, q_ff.sts};
      fsr_pkg::A_EN:    rd = {30'h0, q_ff.en};
      fsr_pkg::A_IDX:   rd = {26'h0, q_ff.idx};
      fsr_pkg::A_DATA:  rd = {24'h0, rb};
      fsr_pkg::A_STATE: rd = {24'h0, 1'b0, q_ff.clk, q_ff.oe, q_ff.out};
      default:          rd = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_q = q_ff;
    wm    = fsr_merge(rd, avs_writedata, avs_byteenable);
    clr   = 2'h0;
    set   = 2'h0;
    // One wait cycle per access keeps read data a flop output
    nxt_q.wt = 1'b1;
    if ((avs_read || avs_write) && q_ff.wt) begin
      nxt_q.wt = 1'b0;
      if (avs_read) begin
        nxt_q.rdata = rd;
      end
    end
    if (avs_write && !q_ff.wt) begin
      case (avs_address)
        fsr_pkg::A_CTRL: begin
          if (wm[fsr_pkg::CTRL_START]) begin
            nxt_q.sub = wm[fsr_pkg::CTRL_SUB];
            set[fsr_pkg::ST_DONE] = 1'b1;
          end
        end
        fsr_pkg::A_CHIP: nxt_q.chip = wm[7:0];
        fsr_pkg::A_VID:  nxt_q.vid = wm[15:0];
        fsr_pkg::A_PID:  nxt_q.pid = wm[15:0];
        fsr_pkg::A_PWR: begin
          nxt_q.pwr = wm[7:0];
          nxt_q.ma  = wm[15:8];
        end
        fsr_pkg::A_GP: begin
          nxt_q.pin0 = wm[7:0];
          nxt_q.pin1 = wm[15:8];
          nxt_q.pin2 = wm[23:16];
        end
        fsr_pkg::A_DIV: nxt_q.div = wm[4:0];
        fsr_pkg::A_CLR: clr = avs_writedata[1:0] & {2{avs_byteenable[0]}};
        fsr_pkg::A_EN:  nxt_q.en = wm[1:0];
        fsr_pkg::A_IDX: nxt_q.idx = wm[5:0];
        default: ;
      endcase
    end
    set[fsr_pkg::ST_INT] = eif.evt;
    // Set beats clear so an event in the clear cycle survives
    nxt_q.sts = (q_ff.sts & ~clr) | set;
    nxt_q.irq = |(nxt_q.sts & nxt_q.en);
    // Settings decode
    nxt_q.vref    = q_ff.chip[fsr_pkg::B_ADC_HI:fsr_pkg::B_ADC_LO];
    nxt_q.vref_on = |q_ff.chip[fsr_pkg::B_ADC_HI:fsr_pkg::B_ADC_LO];
    nxt_q.dac_sup = q_ff.chip[fsr_pkg::B_DAC];
    nxt_q.ma_o    = {q_ff.ma, 1'b0};
    // Divider runs on this block's clock, not a separate 48 MHz one
    if (q_ff.pin1[2:0] == fsr_pkg::F1_CLK) begin
      if (q_ff.cnt == q_ff.div) begin
        nxt_q.cnt = 5'h00;
        nxt_q.clk = ~q_ff.clk;
      end else begin
        nxt_q.cnt = q_ff.cnt + 5'h01;
      end
    end else begin
      nxt_q.cnt = 5'h00;
      nxt_q.clk = 1'b0;
    end
    // Pins default to undriven input
    nxt_q.oe   = 3'h0;
    nxt_q.out  = 3'h0;
    nxt_q.ana1 = 1'b0;
    nxt_q.ana2 = 1'b0;
    nxt_q.dac  = 1'b0;
    unique case (q_ff.pin0[2:0])
      fsr_pkg::F_GPIO: begin
        nxt_q.oe[0]  = !q_ff.pin0[fsr_pkg::B_DIR];
        nxt_q.out[0] = q_ff.pin0[fsr_pkg::B_VAL] &&
                       !q_ff.pin0[fsr_pkg::B_DIR];
      end
      fsr_pkg::F0_SUSP: begin
        nxt_q.oe[0]  = 1'b1;
        nxt_q.out[0] = suspend_indicator;
      end
      fsr_pkg::F0_URX: begin
        nxt_q.oe[0]  = 1'b1;
        nxt_q.out[0] = uart_rx_activity_indicator;
      end
      default: ;
    endcase
    unique case (q_ff.pin1[2:0])
      fsr_pkg::F_GPIO: begin
        nxt_q.oe[1]  = !q_ff.pin1[fsr_pkg::B_DIR];
        nxt_q.out[1] = q_ff.pin1[fsr_pkg::B_VAL] &&
                       !q_ff.pin1[fsr_pkg::B_DIR];
      end
      fsr_pkg::F1_CLK: begin
        nxt_q.oe[1]  = 1'b1;
        nxt_q.out[1] = q_ff.clk;
      end
      fsr_pkg::F1_ADC: nxt_q.ana1 = 1'b1;
      fsr_pkg::F1_UTX: begin
        nxt_q.oe[1]  = 1'b1;
        nxt_q.out[1] = uart_tx_activity_indicator;
      end
      fsr_pkg::F1_INT: ;
      default: ;
    endcase
    unique case (q_ff.pin2[2:0])
      fsr_pkg::F_GPIO: begin
        nxt_q.oe[2]  = !q_ff.pin2[fsr_pkg::B_DIR];
        nxt_q.out[2] = q_ff.pin2[fsr_pkg::B_VAL] &&
                       !q_ff.pin2[fsr_pkg::B_DIR];
      end
      fsr_pkg::F2_CFG: begin
        nxt_q.oe[2]  = 1'b1;
        nxt_q.out[2] = usb_configured_indicator;
      end
      fsr_pkg::F2_ADC: nxt_q.ana2 = 1'b1;
      fsr_pkg::F2_DAC: nxt_q.dac = 1'b1;
      default: ;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q_ff <= ST_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign avs_readdata       = q_ff.rdata;
  assign avs_waitrequest    = q_ff.wt;
  assign irq                = q_ff.irq;
  assign gp_out             = q_ff.out;
  assign gp_oe              = q_ff.oe;
  assign analog_input_1_sel = q_ff.ana1;
  assign analog_input_2_sel = q_ff.ana2;
  assign analog_output_1_en = q_ff.dac;
  assign adc_vref_code      = q_ff.vref;
  assign adc_vref_on        = q_ff.vref_on;
  assign dac_ref_supply     = q_ff.dac_sup;
  assign usb_vid            = q_ff.vid;
  assign usb_pid            = q_ff.pid;
  assign usb_power_attr     = q_ff.pwr;
  assign usb_current_ma     = q_ff.ma_o;

  // ****************************************
  // Checks
  // ****************************************
  chk_echo_code: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (avs_read && q_ff.wt && avs_address == fsr_pkg::A_DATA &&
     q_ff.idx == fsr_pkg::IX_CMD)
    |=> (!avs_waitrequest && avs_readdata == 32'h0000_00b0))
    else $error("command echo missing");
  chk_vid_low: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (avs_read && q_ff.wt && avs_address == fsr_pkg::A_DATA &&
     q_ff.idx == fsr_pkg::IX_VID_LO && !q_ff.sub)
    |=> avs_readdata[7:0] == $past(q_ff.vid[7:0]))
    else $error("vendor id low byte wrong");
  chk_pid_high: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (avs_read && q_ff.wt && avs_address == fsr_pkg::A_DATA &&
     q_ff.idx == fsr_pkg::IX_PID_HI && !q_ff.sub)
    |=> avs_readdata[7:0] == $past(q_ff.pid[15:8]))
    else $error("product id high byte wrong");
  chk_power_attr: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (avs_write && !avs_waitrequest && avs_address == fsr_pkg::A_PWR &&
     avs_byteenable[0])
    |=> usb_power_attr == $past(avs_writedata[7:0]))
    else $error("power attributes not taken");
  chk_ma_twice: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    rstn |=> usb_current_ma == {$past(q_ff.ma), 1'b0})
    else $error("requested current not doubled");
  chk_adc_ref: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    rstn |=> (adc_vref_code == $past(q_ff.chip[4:3]) &&
         adc_vref_on == ($past(q_ff.chip[4:3]) != 2'h0)))
    else $error("converter reference wrong");
  chk_dac_ref: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    rstn |=> dac_ref_supply == $past(q_ff.chip[2]))
    else $error("output reference wrong");
  chk_gpio_drive: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (q_ff.pin0[2:0] == fsr_pkg::F_GPIO && !q_ff.pin0[3])
    |=> (gp_oe[0] && gp_out[0] == $past(q_ff.pin0[4])))
    else $error("gpio output level wrong");
  chk_gpio_input: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (q_ff.pin2[2:0] == fsr_pkg::F_GPIO && q_ff.pin2[3]) |=> !gp_oe[2])
    else $error("gpio input driven");
  chk_suspend_out: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (q_ff.pin0[2:0] == fsr_pkg::F0_SUSP)
    |=> (gp_oe[0] && gp_out[0] == $past(suspend_indicator)))
    else $error("suspend indicator not routed");
  chk_int_input: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (q_ff.pin1[2:0] == fsr_pkg::F1_INT) |=> !gp_oe[1])
    else $error("interrupt pin driven");
  chk_dac_route: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (q_ff.pin2[2:0] == fsr_pkg::F2_DAC)
    |=> (analog_output_1_en && !gp_oe[2]))
    else $error("analog output not routed");
  chk_clk_toggle: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (q_ff.pin1[2:0] == fsr_pkg::F1_CLK && q_ff.cnt == q_ff.div)
    |=> (q_ff.clk != $past(q_ff.clk) && q_ff.cnt == 5'h00))
    else $error("clock divider wrong");
  chk_unused_in: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (q_ff.pin0[2:0] > fsr_pkg::F0_URX) |=> !gp_oe[0])
    else $error("unused code drives pin");
endmodule : fsr_top
`default_nettype wire

// *** tb/fsr_pin_model.sv ***
// Pin-side model: outside drivers meeting the block on its pins
`timescale 1ns/1ps
`default_nettype none
module fsr_pin_model (
  input  wire logic [2:0] ext,
  input  wire logic [2:0] gp_out,
  input  wire logic [2:0] gp_oe,
  output logic      [2:0] gp_in
);
  // Block wins while it drives; otherwise the outside level shows
  assign gp_in = (gp_oe & gp_out) | (~gp_oe & ext);
endmodule : fsr_pin_model
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the settings readback block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        ref_clk, rstn, avs_read, avs_write, avs_waitrequest, irq;
  logic [7:0]  avs_address, pattr;
  logic [31:0] avs_writedata, avs_readdata, rv;
  logic [2:0]  gp_in, gp_out, gp_oe, ext;
  logic        susp, cfg, urx, utx, ai1, ai2, ao1, von, dsup;
  logic [1:0]  vcode;
  logic [15:0] vid, pid;
  logic [8:0]  ma;
  int          errors, comparisons, cyc, k, n;
  // Pin cases: settings word, expected drive enables, expected levels
  logic [31:0] gpw [5] = '{32'h00030210, 32'h00010301, 32'h00000002,
                           32'h00141517, 32'h00080818};
  logic [2:0]  eoe [5] = '{3'h1, 3'h7, 3'h7, 3'h0, 3'h0};
  logic [2:0]  eout[5] = '{3'h1, 3'h5, 3'h1, 3'h0, 3'h0};

  fsr_top dut (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq), .gp_in(gp_in), .gp_out(gp_out), .gp_oe(gp_oe),
    .suspend_indicator(susp), .usb_configured_indicator(cfg),
    .uart_rx_activity_indicator(urx), .uart_tx_activity_indicator(utx),
    .analog_input_1_sel(ai1), .analog_input_2_sel(ai2),
    .analog_output_1_en(ao1), .adc_vref_code(vcode), .adc_vref_on(von),
    .dac_ref_supply(dsup), .usb_vid(vid), .usb_pid(pid),
    .usb_power_attr(pattr), .usb_current_ma(ma));
  fsr_pin_model pins (.ext(ext), .gp_out(gp_out), .gp_oe(gp_oe),
    .gp_in(gp_in));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  // Generous ceiling; the whole run needs well under 2000 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rv = avs_readdata;
    avs_read <= 1'b0;
  endtask : rd

  // Derived outputs lag a settings write by one clock
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic rdb(input logic [5:0] i, input logic [7:0] e);
    wr(fsr_pkg::A_IDX, {26'h0, i});
    rd(fsr_pkg::A_DATA);
    chk("response byte", rv, {24'h0, e});
  endtask : rdb

  task automatic readback(input logic [31:0] c);
    wr(fsr_pkg::A_CTRL, c);
    rv = '0;
    for (int j = 0; j < 20 && rv[0] !== 1'b1; j++) rd(fsr_pkg::A_STS);
    chk("done flag", rv[0], 1'b1);
    wr(fsr_pkg::A_CLR, 32'h1);
  endtask : readback

  task automatic wlev(input logic v, inout int c);
    for (int j = 0; j < 40 && gp_out[1] !== v; j++) begin
      @(posedge ref_clk);
      c++;
    end
  endtask : wlev

  task automatic edge_irq(input logic v, input logic e);
    ext[1] <= v;
    repeat (6) @(posedge ref_clk);
    #1;
    chk("irq", irq, e);
    wr(fsr_pkg::A_CLR, 32'h2);
  endtask : edge_irq

  initial begin
    rstn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    ext = 3'h2;
    susp = 1'b1;
    cfg = 1'b1;
    urx = 1'b1;
    utx = 1'b0;
    errors = 0;
    comparisons = 0;
    cyc = 0;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    settle();
    // ****************************************
    // Reset state and chip byte 7
    // ****************************************
    chk("vid", vid, fsr_pkg::R_VID);
    chk("power attr", pattr, fsr_pkg::R_PWR);
    chk("current", ma, 9'h064);
    chk("oe", gp_oe, 3'h0);
    for (k = 0; k < 4; k++) begin
      wr(fsr_pkg::A_CHIP, 32'(k * 8 + (k % 2) * 4));
      settle();
      chk("vref code", vcode, k[1:0]);
      chk("vref on", von, k != 0);
      chk("dac ref", dsup, k[0]);
    end
    rd(8'hfc);
    chk("unmapped", rv, 32'h0);
    $display("Test chip fields done");
    // ****************************************
    // Chip settings readback
    // ****************************************
    wr(fsr_pkg::A_VID, 32'habcd);
    wr(fsr_pkg::A_PID, 32'h0102);
    wr(fsr_pkg::A_PWR, 32'h7fc0);
    wr(fsr_pkg::A_CHIP, 32'h58);
    settle();
    chk("pid", pid, 16'h0102);
    chk("attr", pattr, 8'hc0);
    chk("current", ma, 9'h0fe);
    readback(32'h1);
    rdb(6'h00, 8'hb0);
    rdb(6'h01, 8'h00);
    rdb(6'h07, 8'h58);
    rdb(6'h08, 8'hcd);
    rdb(6'h09, 8'hab);
    rdb(6'h0a, 8'h02);
    rdb(6'h0b, 8'h01);
    rdb(6'h0c, 8'hc0);
    rdb(6'h0d, 8'h7f);
    $display("Test chip readback done");
    // ****************************************
    // Pin functions and pin readback
    // ****************************************
    for (k = 0; k < 5; k++) begin
      wr(fsr_pkg::A_GP, gpw[k]);
      settle();
      chk("pin oe", gp_oe, eoe[k]);
      chk("pin level", gp_out, eout[k]);
      if (k == 0) begin
        chk("analog_input_1 sel", ai1, 1'b1);
        chk("analog_output_1 en", ao1, 1'b1);
      end
    end
    wr(fsr_pkg::A_GP, 32'h00020001);
    settle();
    chk("analog_input_2 sel", ai2, 1'b1);
    readback(32'h3);
    rdb(6'h02, 8'h08);
    rdb(6'h04, 8'h01);
    rdb(6'h05, 8'h00);
    rdb(6'h06, 8'h02);
    $display("Test pins done");
    // ****************************************
    // Interrupt edges and clock output
    // ****************************************
    wr(fsr_pkg::A_GP, 32'h00000400);
    wr(fsr_pkg::A_CHIP, 32'h40);
    wr(fsr_pkg::A_EN, 32'h2);
    wr(fsr_pkg::A_CLR, 32'h3);
    edge_irq(1'b0, 1'b1);
    edge_irq(1'b1, 1'b0);
    wr(fsr_pkg::A_CHIP, 32'h20);
    edge_irq(1'b0, 1'b0);
    ext[1] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(fsr_pkg::A_STS);
    chk("int status", rv[1], 1'b1);
    wr(fsr_pkg::A_EN, 32'h0);
    settle();
    chk("irq masked", irq, 1'b0);
    wr(fsr_pkg::A_DIV, 32'h2);
    wr(fsr_pkg::A_GP, 32'h00000100);
    settle();
    chk("clk oe", gp_oe[1], 1'b1);
    n = 0;
    wlev(1'b0, n);
    wlev(1'b1, n);
    n = 0;
    wlev(1'b0, n);
    wlev(1'b1, n);
    chk("clk period", n, 32'd6);
    $display("Test interrupt and clock done");
    end_sim();
  end
endmodule : testbench
`default_nettype wire
